// >>> cbs_card_model.sv
`default_nettype none

// ********************************************************
// Card side of the clock-run handshake.
// ********************************************************
module cbs_card_model (
    input wire logic card_clk,
    input wire logic card_rst_b,
    input wire logic want_fast,
    output logic pull_low,
    output logic [3:0] seq_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // request or float
    // Asynchronous, so a card can wake a stopped clock.
    assign pull_low = card_rst_b & want_fast;

    always_ff @(posedge card_clk or negedge card_rst_b) begin
        if (!card_rst_b) begin
            seq_q <= 4'h0;
        end else begin
            seq_q <= seq_q + 4'h1;
        end
    end
endmodule : cbs_card_model

`default_nettype wire

// >>> cbs_pkg.sv
`default_nettype none

package cbs_pkg;

    // ****************************************************************
    // Clock-run sequencer states, Gray coded along the slowdown path.
    // ****************************************************************
    typedef enum logic [1:0] {
        CBS_RUN      = 2'h0,
        CBS_ANNOUNCE = 2'h1,
        CBS_LISTEN   = 2'h3,
        CBS_SAVE     = 2'h2
    } cbs_state_t;

    // ****************************************************************
    // Cycle counts on the host bus clock and reset values.
    // ****************************************************************
    localparam logic [2:0] CBS_ANNOUNCE_CYC = 3'h2;
    localparam logic [2:0] CBS_LISTEN_CYC = 3'h4;
    localparam logic [2:0] CBS_SLOW_DIV = 3'h7;
    localparam logic [2:0] CBS_CNT_RST = 3'h0;
    localparam logic CBS_GATE_RST = 1'h1;
    localparam logic CBS_STOP_RST = 1'h0;

    // ****************************************************************
    // Carriers between the system side and the socket logic.
    // ****************************************************************
    typedef struct packed {
        logic stop;
        logic slow;
        logic reset;
    } cbs_ctrl_t;

    typedef struct packed {
        logic full;
        logic stopped;
        logic slowed;
        logic reset_active;
    } cbs_stat_t;

endpackage : cbs_pkg

`default_nettype wire

// >>> cbs_socket_ctrl.sv
// Behaviour
// RL1: Socket lines sample on card clock rises; clock-run and reset do not.
// RL2: Card clock runs at host bus rate, may slow, stops only low.
// RL3: Card requests a faster clock by pulling the clock-run line low.
// RL4: Controller flags a slowdown on clock-run before slowing or stopping.
// RL5: Card resets its own registers and sequencers while card reset active.
// RL6: During card reset the card floats, controller parks socket lines.
// RL7: Card reset asserts anytime, releases only on a card clock edge.
// RL8: A card clock-run request cancels or ends any slowdown at once.
`default_nettype none

module cbs_socket_ctrl
    import cbs_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic HOST_BUS_CLK,
    input wire cbs_ctrl_t CTRL_REQ,
    output cbs_stat_t STATUS,
    output logic SOCKET_CARD_CLOCK,
    output logic SOCKET_CARD_RESET_B,
    input wire logic CLOCK_RUN_REQUEST_LINE_IN,
    output logic CLOCK_RUN_REQUEST_LINE_OUT,
    output logic CLOCK_RUN_REQUEST_LINE_OE,
    output logic SOCKET_LINES_PARK
);

    // ****************************************************************
    // System clock side.
    // ****************************************************************
    cbs_ctrl_t ctrl_q;
    cbs_stat_t stat_lnk_q;
    cbs_stat_t stat_sys;
    logic card_rst_src_b;

    // Requests come from logic on SYS_CLK, so one register is enough.
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q <= CTRL_REQ;
        end
    end

    // Each status bit is an independent level, so bitwise sync is safe.
    cbs_sync #(.WIDTH(4)) u_stat_sync (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .d(stat_lnk_q),
        .q(stat_sys)
    );
    assign STATUS = stat_sys;

    // ****************************************************************
    // Link domain reset and card reset.
    // ****************************************************************
    logic [1:0] lnk_rst_q;
    logic lnk_rst_b;
    logic [1:0] socket_card_reset_q;
    logic park_q;
    logic card_in_reset;

    always_ff @(posedge HOST_BUS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            lnk_rst_q <= 2'h0;
        end else begin
            lnk_rst_q <= {lnk_rst_q[0], 1'h1};
        end
    end
    assign lnk_rst_b = lnk_rst_q[1];

    // RL7 async assert sync release
    // The request flop clears the chain at once; release walks two edges.
    assign card_rst_src_b = RST_B & ~ctrl_q.reset;
    always_ff @(posedge HOST_BUS_CLK or negedge card_rst_src_b) begin
        if (!card_rst_src_b) begin
            socket_card_reset_q <= 2'h0;
        end else begin
            socket_card_reset_q <= {socket_card_reset_q[0], 1'h1};
        end
    end
    assign SOCKET_CARD_RESET_B = socket_card_reset_q[1];
    assign card_in_reset = ~socket_card_reset_q[1];

    // RL6 park socket lines
    // Parking holds one edge past release so the card sees a clean hand-off.
    always_ff @(posedge HOST_BUS_CLK or negedge card_rst_src_b) begin
        if (!card_rst_src_b) begin
            park_q <= 1'h1;
        end else begin
            park_q <= card_in_reset;
        end
    end
    assign SOCKET_LINES_PARK = park_q;

    // ****************************************************************
    // Clock-run sequencer on the host bus clock.
    // ****************************************************************
    logic [1:0] req_s;
    logic run_line_s;
    logic save_req;
    logic card_req;
    cbs_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic stop_mode_q;
    logic run_oe_q, run_out_q;
    logic [1:0] own_low_q;
    logic socket_card_reset_s;

    cbs_sync #(.WIDTH(2)) u_req_sync (
        .clk(HOST_BUS_CLK),
        .rst_b(lnk_rst_b),
        .d({ctrl_q.stop, ctrl_q.slow}),
        .q(req_s)
    );

    // RL1 async clock-run sampling
    // The line is not timed to the card clock, so it is synchronised.
    cbs_sync #(.WIDTH(1)) u_run_sync (
        .clk(HOST_BUS_CLK),
        .rst_b(lnk_rst_b),
        .d(~CLOCK_RUN_REQUEST_LINE_IN),
        .q(run_line_s)
    );
    // Our own low drive, delayed like the synchroniser, is not a request.
    always_ff @(posedge HOST_BUS_CLK or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            own_low_q <= 2'h3;
        end else begin
            own_low_q <= {own_low_q[0], run_oe_q & ~run_out_q};
        end
    end
    assign card_req = run_line_s & ~own_low_q[1];
    // Card reset starts on the system clock, so it is synchronised here.
    cbs_sync #(.WIDTH(1)) u_socket_card_reset_sync (
        .clk(HOST_BUS_CLK),
        .rst_b(lnk_rst_b),
        .d(card_in_reset),
        .q(socket_card_reset_s)
    );
    assign save_req = (req_s[1] | req_s[0]) & ~socket_card_reset_s;

    // RL4 announce then listen
    // A slowdown passes through an announce phase and a listen window.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 3'h1;
        case (state_q)
            CBS_RUN: begin
                cnt_d = CBS_CNT_RST;
                if (save_req && !card_req) begin
                    state_d = CBS_ANNOUNCE;
                end
            end
            CBS_ANNOUNCE: begin
                if (card_req || !save_req) begin
                    state_d = CBS_RUN;
                end else if (cnt_q == CBS_ANNOUNCE_CYC - 3'h1) begin
                    state_d = CBS_LISTEN;
                    cnt_d = CBS_CNT_RST;
                end
            end
            CBS_LISTEN: begin
                if (card_req || !save_req) begin
                    state_d = CBS_RUN;
                end else if (cnt_q == CBS_LISTEN_CYC - 3'h1) begin
                    state_d = CBS_SAVE;
                    cnt_d = CBS_CNT_RST;
                end
            end
            CBS_SAVE: begin
                // RL8 card request restores
                if (card_req || !save_req) begin
                    state_d = CBS_RUN;
                end else if (cnt_q == CBS_SLOW_DIV) begin
                    cnt_d = CBS_CNT_RST;
                end
            end
            default: begin
                state_d = CBS_RUN;
            end
        endcase
    end

    always_ff @(posedge HOST_BUS_CLK or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            state_q <= CBS_RUN;
            cnt_q <= CBS_CNT_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Stop wins over slow; the choice is frozen for the whole saving spell.
    always_ff @(posedge HOST_BUS_CLK or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            stop_mode_q <= CBS_STOP_RST;
        end else if (state_q == CBS_LISTEN && state_d == CBS_SAVE) begin
            stop_mode_q <= req_s[1];
        end
    end

    // RL4 drive clock-run line
    // Low while running, high to announce, released while listening.
    always_ff @(posedge HOST_BUS_CLK or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            run_oe_q <= 1'h1;
            run_out_q <= 1'h0;
        end else begin
            run_oe_q <= (state_d == CBS_RUN) || (state_d == CBS_ANNOUNCE);
            run_out_q <= (state_d == CBS_ANNOUNCE);
        end
    end
    assign CLOCK_RUN_REQUEST_LINE_OE = run_oe_q;
    assign CLOCK_RUN_REQUEST_LINE_OUT = run_out_q;

    // Status bits for the system side, all from flops.
    always_ff @(posedge HOST_BUS_CLK or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            stat_lnk_q <= '0;
        end else begin
            stat_lnk_q.full <= (state_q != CBS_SAVE);
            stat_lnk_q.stopped <= (state_q == CBS_SAVE) && stop_mode_q;
            stat_lnk_q.slowed <= (state_q == CBS_SAVE) && !stop_mode_q;
            stat_lnk_q.reset_active <= card_in_reset;
        end
    end

    // ****************************************************************
    // Card clock gate.
    // ****************************************************************
    logic gate_q;

    // RL2 glitch-free clock gate
    // The enable moves on the falling edge, so the gated clock is
    // never cut short and stays low while stopped.
    always_ff @(negedge HOST_BUS_CLK or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            gate_q <= CBS_GATE_RST;
        end else begin
            gate_q <= (state_q != CBS_SAVE) ||
                      (!stop_mode_q && cnt_q == CBS_CNT_RST);
        end
    end
    assign SOCKET_CARD_CLOCK = HOST_BUS_CLK & gate_q;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    chk_stop_clock_low: assert property ( // RL2
        @(posedge HOST_BUS_CLK) disable iff (!lnk_rst_b)
        (state_q == CBS_SAVE && stop_mode_q)[*2] |-> !gate_q)
        else $error("Card clock not held low while stopped.");

    chk_run_full_rate: assert property ( // RL2
        @(posedge HOST_BUS_CLK) disable iff (!lnk_rst_b)
        (state_q == CBS_RUN)[*2] |-> gate_q)
        else $error("Card clock gated while running at full rate.");

    chk_announce_pulse: assert property ( // RL4
        @(posedge HOST_BUS_CLK) disable iff (!lnk_rst_b)
        $rose(state_q == CBS_ANNOUNCE) && save_req && !card_req
        ##1 save_req && !card_req
        |-> $past(run_oe_q && run_out_q) ##1 !run_oe_q)
        else $error("Slowdown announcement has wrong shape.");

    chk_save_after_listen: assert property ( // RL4
        @(posedge HOST_BUS_CLK) disable iff (!lnk_rst_b)
        $rose(state_q == CBS_SAVE) |-> $past(state_q) == CBS_LISTEN)
        else $error("Clock slowed without announcement.");

    chk_card_req_restore: assert property ( // RL8
        @(posedge HOST_BUS_CLK) disable iff (!lnk_rst_b)
        (state_q != CBS_RUN && card_req) |=> state_q == CBS_RUN ##1 gate_q)
        else $error("Card clock request not honoured.");

    chk_reset_parks: assert property ( // RL6
        @(posedge HOST_BUS_CLK) disable iff (!lnk_rst_b)
        card_in_reset |-> park_q)
        else $error("Socket lines not parked during card reset.");

    chk_reset_clock_runs: assert property ( // RL7
        @(posedge HOST_BUS_CLK) disable iff (!lnk_rst_b)
        $rose(SOCKET_CARD_RESET_B) |-> gate_q && state_q != CBS_SAVE)
        else $error("Card reset released without a card clock edge.");

    cov_stop: cover property (@(posedge HOST_BUS_CLK)
        state_q == CBS_SAVE && stop_mode_q);
    cov_slow: cover property (@(posedge HOST_BUS_CLK)
        state_q == CBS_SAVE && !stop_mode_q);
    cov_abort: cover property (@(posedge HOST_BUS_CLK)
        state_q == CBS_LISTEN && card_req);

endmodule : cbs_socket_ctrl

`default_nettype wire

// >>> cbs_sync.sv
`default_nettype none

// ********************************************************************
// Two-stage level synchroniser; the first stage feeds only the second.
// ********************************************************************
module cbs_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    // Both stages clear under reset so the receiver sees a quiet level.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : cbs_sync

`default_nettype wire

// >>> test_cbs_socket_ctrl.sv
`default_nettype none

module test_cbs_socket_ctrl
    import cbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************************************
    // Clocks, wire and instances.
    // ********************************************************
    logic sys_clk, host_clk, rst_b, want_fast, saw_ann;
    logic socket_card_clock, socket_card_reset_b, crl_in, crl_out, crl_oe, park, pull_low;
    logic [3:0] seq;
    logic [2:0] s;
    cbs_ctrl_t ctrl;
    cbs_stat_t stat;
    int err_total, checks_done, socket_card_clock_n;

    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        host_clk = 1'h0;
        #3.7;
        forever #6 host_clk = ~host_clk;
    end

    // Pull-up on the shared line; any party driving low wins.
    assign crl_in = !(pull_low || (crl_oe && !crl_out));

    cbs_socket_ctrl dut_u (.SYS_CLK(sys_clk), .RST_B(rst_b),
        .HOST_BUS_CLK(host_clk), .CTRL_REQ(ctrl), .STATUS(stat),
        .SOCKET_CARD_CLOCK(socket_card_clock), .SOCKET_CARD_RESET_B(socket_card_reset_b),
        .CLOCK_RUN_REQUEST_LINE_IN(crl_in),
        .CLOCK_RUN_REQUEST_LINE_OUT(crl_out),
        .CLOCK_RUN_REQUEST_LINE_OE(crl_oe), .SOCKET_LINES_PARK(park));
    cbs_card_model card_u (.card_clk(socket_card_clock), .card_rst_b(socket_card_reset_b),
        .want_fast(want_fast), .pull_low(pull_low), .seq_q(seq));

    // ********************************************************
    // Checking helpers.
    // ********************************************************
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'h1) begin
            err_total++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic finish_test;
        $display("Checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // A held card request always wins over a slowdown.
    function automatic cbs_stat_t exp_stat(logic st, logic sl, logic f);
        cbs_stat_t r;
        r = '0;
        if (f || !(st || sl)) r.full = 1'h1;
        else if (st) r.stopped = 1'h1;
        else r.slowed = 1'h1;
        return r;
    endfunction : exp_stat

    task automatic apply(input logic st, input logic sl, input logic f);
        @(negedge sys_clk);
        ctrl.stop = st;
        ctrl.slow = sl;
        want_fast = f;
    endtask : apply

    task automatic wait_stat(input cbs_stat_t e);
        for (int i = 0; i < 30 && stat !== e; i++) @(negedge sys_clk);
        chk(stat === e, "status mismatch");
    endtask : wait_stat

    // Counts card clock rises over 80 host clocks, one of slack.
    task automatic rate(input int e);
        int n0;
        n0 = socket_card_clock_n;
        repeat (80) @(posedge host_clk);
        chk((socket_card_clock_n - n0) >= e - 1 && (socket_card_clock_n - n0) <= e + 1, "rate");
    endtask : rate

    always @(posedge socket_card_clock) socket_card_clock_n++;
    always @(posedge host_clk) begin
        if (crl_oe === 1'h1 && crl_out === 1'h1) saw_ann = 1'h1;
    end
    always @(posedge stat.stopped or posedge stat.slowed) begin
        chk(saw_ann === 1'h1, "no slowdown notice");
        saw_ann = 1'h0;
    end
    always @(posedge socket_card_reset_b) begin
        #1;
        chk(socket_card_clock === 1'h1, "reset release off edge");
    end

    // ********************************************************
    // Main sequence and watchdog.
    // ********************************************************
    initial begin
        err_total = 0;
        checks_done = 0;
        socket_card_clock_n = 0;
        saw_ann = 1'h0;
        ctrl = '0;
        want_fast = 1'h0;
        rst_b = 1'h0;
        s = 3'h0;
        void'($urandom(32'h05D7));
        repeat (4) @(negedge sys_clk);
        chk(socket_card_reset_b === 1'h0 && park === 1'h1, "reset park");
        chk(crl_oe === 1'h1 && crl_out === 1'h0, "reset run");
        rst_b = 1'h1;
        repeat (3) @(negedge sys_clk);
        chk(socket_card_reset_b === 1'h1 && park === 1'h0, "release");
        rate(80);
        apply(1'h1, 1'h0, 1'h0);
        wait_stat(exp_stat(1'h1, 1'h0, 1'h0));
        rate(0);
        chk(socket_card_clock === 1'h0, "stopped high");
        apply(1'h1, 1'h0, 1'h1);
        wait_stat(exp_stat(1'h1, 1'h0, 1'h1));
        rate(80);
        apply(1'h0, 1'h1, 1'h0);
        wait_stat(exp_stat(1'h0, 1'h1, 1'h0));
        rate(10);
        apply(1'h0, 1'h0, 1'h0);
        wait_stat(exp_stat(1'h0, 1'h0, 1'h0));
        // Mid-run card reset; a stop request meanwhile is refused.
        @(negedge sys_clk);
        ctrl = '{stop: 1'h1, slow: 1'h0, reset: 1'h1};
        repeat (2) @(negedge sys_clk);
        chk(socket_card_reset_b === 1'h0 && park === 1'h1, "mid reset");
        rate(80);
        chk(stat.stopped === 1'h0 && seq === 4'h0, "refuse");
        chk(stat.reset_active === 1'h1, "reset status");
        @(negedge sys_clk);
        ctrl = '0;
        repeat (3) @(negedge sys_clk);
        chk(socket_card_reset_b === 1'h1, "mid release");
        repeat (12) begin
            s = 3'($urandom);
            apply(s[0], s[1], s[2]);
            wait_stat(exp_stat(s[0], s[1], s[2]));
            apply(1'h0, 1'h0, 1'h0);
            wait_stat(exp_stat(1'h0, 1'h0, 1'h0));
        end
        finish_test();
    end

    initial begin
        #300us;
        err_total++;
        $display("Error at %0t: watchdog", $time);
        finish_test();
    end
endmodule : test_cbs_socket_ctrl

`default_nettype wire
